/* File: rtl/mcr_top.sv */
/*
 * Clock distribution and reset control of the Ethernet mapper, with APB
 * access to the global and serial interface control registers.
 * Assumes pclk runs without gaps; all other clocks arrive as plain pins.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
// How it works
// RULE_01: SDRAM clock is the buffered system clock.
// RULE_02: Reference clock is system clock divided down.
// RULE_03: Select pin low gives 25MHz, high 50MHz; the code divides the 125MHz pclk to 31.25MHz and 62.5MHz.
// RULE_04: Management clock near 1.67MHz from system clock.
// RULE_05: DCE MII clocks divided from reference input.
// RULE_06: In DTE the PHY drives MII clocks.
// RULE_07: RMII uses only reference clock; MII clocks idle.
// RULE_08: Off bit stops the reference clock output.
// RULE_09: Serial clocks may be gapped; data still moves.
// RULE_10: Serial line clocks run at 8.192MHz.
// RULE_11: System clock must be gapless, about 100ppm.
// RULE_12: Global reset is pin or software bit.
// RULE_13: Global reset clears all but its own bit.
// RULE_14: Bus outputs float while reset pin is low.
// RULE_15: Software reset bit sticky until zero or pin.
// RULE_16: Host waits 5ms after starting a reset.
// RULE_17: Serial reset clears serial port state only.
// RULE_18: Serial reset bit sticky; cleared by global reset.
// RULE_19: Held reset keeps the block quiet and idle.
// RULE_20: Queue pointer write pulses the pointer reset.
// RULE_21: Global registers decode in 0F0h to 0FFh.
// RULE_22: Host writes zero to unused registers.
// RULE_23: Divide by four for MII, two for RMII.
`timescale 1ns/10ps
`default_nettype none
`include "mcr_defines.svh"

module mcr_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             bus_out_oe_n,
   input  wire logic        reduced_mii_select_pin,
   input  wire logic        ref_clk_in,
   input  wire logic        mii_tx_clk_in,
   input  wire logic        mii_rx_clk_in,
   output logic             mii_tx_clk_out,
   output logic             mii_tx_clk_oe_n,
   output logic             mii_rx_clk_out,
   output logic             mii_rx_clk_oe_n,
   output logic             sdram_clock_out,
   output logic             divided_ethernet_refclk_out,
   output logic             mdc_out,
   input  wire logic        serial_tx_line_clock,
   input  wire logic        serial_rx_line_clock,
   input  wire logic        serial_rx_data,
   output logic             serial_tx_data,
   output logic             queue_ptr_reset_pulse,
   output logic             serial_iface_in_reset
);

   localparam int NSYNC = 7;

   logic [NSYNC-1:0]    pin_raw;
   logic [NSYNC-1:0]    sync1_reg;
   logic [NSYNC-1:0]    sync2_reg;
   logic                rmii_s;
   logic                ref_s;
   logic                txin_s;
   logic                rxin_s;
   logic                stxc_s;
   logic                srxc_s;
   logic                srxd_s;
   logic                glob;
   logic                setup;
   logic                wr_acc;
   logic                hit;
   logic [31:0]         rd_data;
   logic                sw_reset_reg, sw_reset_next;
   logic                refclk_off_reg, refclk_off_next;
   mcr_pkg::mcr_clk_cfg_t cfg_reg, cfg_next;
   logic                ser_rst_reg, ser_rst_next;
   logic [7:0]          ser_tx_byte_reg, ser_tx_byte_next;
   logic                qptr_pulse_reg, qptr_pulse_next;
   logic [31:0]         prdata_reg, prdata_next;
   logic                pready_reg, pready_next;
   logic                pslverr_reg, pslverr_next;
   logic                bus_oe_n_reg;
   logic [7:0]          ref_half;
   logic                refclk_div;
   logic                mdc_div;
   logic                ref_prev_reg;
   logic                ref_rise;
   logic                dce;
   logic [2:0]          mii10_cnt_reg, mii10_cnt_next;
   mcr_pkg::mcr_mii_drv_t mii_reg, mii_next;
   logic                ser_hold;
   logic                stxc_prev_reg;
   logic                srxc_prev_reg;
   logic                rx_rise;
   logic                tx_fall;
   mcr_pkg::mcr_ser_rx_t  rx_reg, rx_next;
   mcr_pkg::mcr_ser_tx_t  tx_reg, tx_next;

   // Every pin from outside except the APB bus and presetn passes two flip-flops before any logic reads it.
   assign pin_raw = {serial_rx_data, serial_rx_line_clock, serial_tx_line_clock,
                     mii_rx_clk_in, mii_tx_clk_in, ref_clk_in, reduced_mii_select_pin};
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_reg[i] <= 1'b0;
               sync2_reg[i] <= 1'b0;
            end else begin
               sync1_reg[i] <= pin_raw[i];
               sync2_reg[i] <= sync1_reg[i];
            end
         end
      end
   endgenerate
   assign {srxd_s, srxc_s, stxc_s, rxin_s, txin_s, ref_s, rmii_s} = sync2_reg;

   // The software bit joins the pin, which acts through the async reset.
   assign glob   = sw_reset_reg; // RULE_12
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pready_reg && pwrite;

   // Address decode and read multiplexer, taken in the setup cycle.
   always_comb begin
      hit     = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr) // RULE_21
         `MCR_OFF_GL_CTRL1: begin
            rd_data[`MCR_BIT_SW_RESET]   = sw_reset_reg;
            rd_data[`MCR_BIT_REFCLK_OFF] = refclk_off_reg;
         end
         `MCR_OFF_GL_ID:     rd_data[15:0] = {`MCR_ID_HIGH_DEF, `MCR_ID_LOW_DEF};
         `MCR_OFF_GL_QPTR:   rd_data = 32'h0000_0000;
         `MCR_OFF_GL_CLKCFG: begin
            rd_data[`MCR_BIT_DCE]       = cfg_reg.dce_mode;
            rd_data[`MCR_BIT_SPEED100]  = cfg_reg.speed_100;
            rd_data[`MCR_BIT_RMII_PIN]  = rmii_s;
            rd_data[`MCR_BIT_TXCLK_PIN] = txin_s;
            rd_data[`MCR_BIT_RXCLK_PIN] = rxin_s;
         end
         `MCR_OFF_SER_RST:   rd_data[`MCR_BIT_SER_RST] = ser_rst_reg;
         `MCR_OFF_SER_TX:    rd_data[7:0] = ser_tx_byte_reg;
         `MCR_OFF_SER_STAT:  rd_data[10:0] = {rx_reg.cnt, rx_reg.byte_q};
         default:            hit = 1'b0;
      endcase
   end

   // Register writes and the bus answer, one access phase with no wait.
   always_comb begin
      sw_reset_next    = sw_reset_reg;
      refclk_off_next  = refclk_off_reg;
      cfg_next         = cfg_reg;
      ser_rst_next     = ser_rst_reg;
      ser_tx_byte_next = ser_tx_byte_reg;
      if (wr_acc && paddr == `MCR_OFF_GL_CTRL1) begin
         sw_reset_next = pwdata[`MCR_BIT_SW_RESET]; // RULE_15
      end
      if (glob) begin
         refclk_off_next  = 1'b0; // RULE_13
         cfg_next         = '0;
         ser_rst_next     = 1'b0; // RULE_18
         ser_tx_byte_next = 8'h00;
      end else if (wr_acc) begin
         if (paddr == `MCR_OFF_GL_CTRL1) begin
            refclk_off_next = pwdata[`MCR_BIT_REFCLK_OFF];
         end
         if (paddr == `MCR_OFF_GL_CLKCFG) begin
            cfg_next.dce_mode  = pwdata[`MCR_BIT_DCE];
            cfg_next.speed_100 = pwdata[`MCR_BIT_SPEED100];
         end
         if (paddr == `MCR_OFF_SER_RST) begin
            ser_rst_next = pwdata[`MCR_BIT_SER_RST]; // RULE_18
         end
         if (paddr == `MCR_OFF_SER_TX) begin
            ser_tx_byte_next = pwdata[7:0];
         end
      end
      qptr_pulse_next = !glob && wr_acc && paddr == `MCR_OFF_GL_QPTR; // RULE_20
      prdata_next     = (setup && !pwrite) ? rd_data : 32'h0000_0000;
      pready_next     = setup;
      pslverr_next    = setup && !hit;
   end

   // Only the pin clears the software reset bit asynchronously.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_reset_reg    <= 1'b0; // RULE_15
         refclk_off_reg  <= 1'b0;
         cfg_reg         <= '0;
         ser_rst_reg     <= 1'b0;
         ser_tx_byte_reg <= 8'h00;
         qptr_pulse_reg  <= 1'b0;
         prdata_reg      <= 32'h0000_0000;
         pready_reg      <= 1'b0;
         pslverr_reg     <= 1'b0;
         bus_oe_n_reg    <= 1'b1; // RULE_14
      end else begin
         sw_reset_reg    <= sw_reset_next;
         refclk_off_reg  <= refclk_off_next;
         cfg_reg         <= cfg_next;
         ser_rst_reg     <= ser_rst_next;
         ser_tx_byte_reg <= ser_tx_byte_next;
         qptr_pulse_reg  <= qptr_pulse_next;
         prdata_reg      <= prdata_next;
         pready_reg      <= pready_next;
         pslverr_reg     <= pslverr_next;
         bus_oe_n_reg    <= 1'b0;
      end
   end

   // The reference clock divides by four for MII and by two for RMII.
   assign ref_half = rmii_s ? `MCR_REF_HALF_RMII : `MCR_REF_HALF_MII; // RULE_23

   mcr_clkdiv #(.W(8)) u_refclk_div (
      .pclk       (pclk),
      .presetn    (presetn),
      .hold       (glob || refclk_off_reg), // RULE_08
      .half_count (ref_half), // RULE_02
      .clk_out    (refclk_div)
   );

   mcr_clkdiv #(.W(8)) u_mdc_div (
      .pclk       (pclk),
      .presetn    (presetn),
      .hold       (glob), // RULE_19
      .half_count (8'(`MCR_MDC_HALF)), // RULE_04
      .clk_out    (mdc_div)
   );

   // The MII clocks are driven only in MII DCE mode; DTE leaves the pins to the PHY.
   assign ref_rise = ref_s && !ref_prev_reg;
   assign dce      = cfg_reg.dce_mode && !rmii_s && !glob; // RULE_07
   always_comb begin
      mii_next       = mii_reg;
      mii10_cnt_next = mii10_cnt_reg;
      if (!dce) begin
         mii_next.clk   = 1'b0; // RULE_06
         mii_next.oe_n  = 1'b1;
         mii10_cnt_next = 3'h0;
      end else if (cfg_reg.speed_100) begin
         mii_next.clk  = ref_s; // RULE_05
         mii_next.oe_n = 1'b0;
      end else begin
         mii_next.oe_n = 1'b0;
         if (ref_rise) begin
            if (mii10_cnt_reg == `MCR_MII10_EDGES - 3'h1) begin
               mii10_cnt_next = 3'h0;
               mii_next.clk   = ~mii_reg.clk; // RULE_05
            end else begin
               mii10_cnt_next = mii10_cnt_reg + 3'h1;
            end
         end
      end
   end

   // Registers the MII clock drive and the reference edge detector.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mii_reg       <= '{clk: 1'b0, oe_n: 1'b1};
         mii10_cnt_reg <= 3'h0;
         ref_prev_reg  <= 1'b0;
      end else begin
         mii_reg       <= mii_next;
         mii10_cnt_reg <= mii10_cnt_next;
         ref_prev_reg  <= ref_s;
      end
   end

   // Serial shifters move one bit per line clock edge, so gaps only pause them.
   assign ser_hold = glob || ser_rst_reg; // RULE_17
   assign rx_rise  = srxc_s && !srxc_prev_reg;
   assign tx_fall  = !stxc_s && stxc_prev_reg;
   always_comb begin
      rx_next = rx_reg;
      tx_next = tx_reg;
      if (ser_hold) begin
         rx_next = '0; // RULE_17
         tx_next = '{shift: 8'h00, cnt: 3'h0, data: 1'b1};
      end else begin
         if (rx_rise) begin
            rx_next.shift = {rx_reg.shift[6:0], srxd_s}; // RULE_09
            rx_next.cnt   = rx_reg.cnt + 3'h1;
            if (rx_reg.cnt == 3'h7) begin
               rx_next.byte_q = {rx_reg.shift[6:0], srxd_s};
            end
         end
         if (tx_fall) begin
            if (tx_reg.cnt == 3'h0) begin
               tx_next.data  = ser_tx_byte_reg[7]; // RULE_09
               tx_next.shift = {ser_tx_byte_reg[6:0], 1'b0};
            end else begin
               tx_next.data  = tx_reg.shift[7];
               tx_next.shift = {tx_reg.shift[6:0], 1'b0};
            end
            tx_next.cnt = tx_reg.cnt + 3'h1;
         end
      end
   end

   // Registers the serial shifters and the line clock edge detectors.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_reg        <= '0;
         tx_reg        <= '{shift: 8'h00, cnt: 3'h0, data: 1'b1};
         stxc_prev_reg <= 1'b0;
         srxc_prev_reg <= 1'b0;
      end else begin
         rx_reg        <= rx_next;
         tx_reg        <= tx_next;
         stxc_prev_reg <= stxc_s;
         srxc_prev_reg <= srxc_s;
      end
   end

   // Outputs; the SDRAM clock is forwarded as it cannot pass through a flop.
   assign sdram_clock_out             = pclk; // RULE_01
   assign divided_ethernet_refclk_out = refclk_div; // RULE_03
   assign mdc_out                     = mdc_div;
   assign mii_tx_clk_out              = mii_reg.clk;
   assign mii_rx_clk_out              = mii_reg.clk;
   assign mii_tx_clk_oe_n             = mii_reg.oe_n;
   assign mii_rx_clk_oe_n             = mii_reg.oe_n;
   assign serial_tx_data              = tx_reg.data;
   assign serial_iface_in_reset       = ser_rst_reg;
   assign queue_ptr_reset_pulse       = qptr_pulse_reg;
   assign prdata                      = prdata_reg;
   assign pready                      = pready_reg;
   assign pslverr                     = pslverr_reg;
   assign bus_out_oe_n                = bus_oe_n_reg;

   // Helper state that measures management clock half periods.
   logic       mdc_prev_a;
   logic       mdc_seen_a;
   logic [7:0] mdc_age_a;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mdc_prev_a <= 1'b0;
         mdc_seen_a <= 1'b0;
         mdc_age_a  <= 8'h00;
      end else begin
         mdc_prev_a <= mdc_out;
         mdc_seen_a <= !glob && (mdc_seen_a || mdc_out != mdc_prev_a);
         mdc_age_a  <= (glob || mdc_out != mdc_prev_a) ? 8'h00 : mdc_age_a + 8'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence ref_run_s;
      !glob && !refclk_off_reg && rmii_s;
   endsequence
   sequence mii_run_s;
      !glob && !refclk_off_reg && !rmii_s;
   endsequence

   refclk_off_holds_a: assert property (refclk_off_reg ##1 refclk_off_reg |=> !divided_ethernet_refclk_out) // RULE_08
      else $error("Reference clock runs while switched off.");
   rmii_div_two_a: assert property ( // RULE_23
      ref_run_s ##1 ref_run_s |=> ref_run_s |-> $changed(divided_ethernet_refclk_out))
      else $error("RMII reference clock is not half the system clock.");
   mii_div_four_a: assert property ( // RULE_03
      mii_run_s ##1 (mii_run_s and $changed(divided_ethernet_refclk_out)) ##1 mii_run_s
      |-> $stable(divided_ethernet_refclk_out))
      else $error("MII reference clock toggles too fast.");
   mdc_half_period_a: assert property ( // RULE_04
      (mdc_seen_a && !glob && mdc_out != mdc_prev_a) |-> mdc_age_a == 8'(`MCR_MDC_HALF - 1))
      else $error("Management clock half period is wrong.");
   sw_reset_sticky_a: assert property ( // RULE_15
      sw_reset_reg && !(wr_acc && paddr == `MCR_OFF_GL_CTRL1) |=> sw_reset_reg)
      else $error("Software reset bit cleared by itself.");
   glob_clears_cfg_a: assert property (glob |=> cfg_reg == '0 && !refclk_off_reg && !ser_rst_reg) // RULE_13
      else $error("Global reset left control bits set.");
   ser_reset_quiet_a: assert property (ser_rst_reg |=> rx_reg == '0 && serial_tx_data) // RULE_17
      else $error("Serial state moves under serial reset.");
   qptr_pulse_once_a: assert property ( // RULE_20
      !glob && wr_acc && paddr == `MCR_OFF_GL_QPTR |=> queue_ptr_reset_pulse ##1 !queue_ptr_reset_pulse)
      else $error("Queue pointer reset pulse missing or long.");
   unmapped_error_a: assert property (setup && !hit |=> pready && pslverr) // RULE_21
      else $error("Unmapped access not refused.");
   mii10_on_edge_a: assert property ( // RULE_05
      dce && !cfg_reg.speed_100 && $past(dce && !cfg_reg.speed_100) && $changed(mii_tx_clk_out)
      |-> $past(ref_rise))
      else $error("10 Mbps MII clock moved off a reference edge.");
   rmii_mii_idle_a: assert property (rmii_s |=> mii_tx_clk_oe_n && mii_rx_clk_oe_n) // RULE_07
      else $error("MII clocks driven in RMII mode.");
   serial_rx_step_a: assert property (!ser_hold && rx_rise |=> rx_reg.cnt == 3'($past(rx_reg.cnt) + 3'h1)) // RULE_09
      else $error("Serial receive bit not taken on clock edge.");

endmodule

`default_nettype wire

/* File: common/mcr_defines.svh */
/*
 * Constants of the mapper clock and reset control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name from files that need these values.
 */
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

// Clock rate of pclk and the wanted management data clock, both in kHz.
`define MCR_PCLK_KHZ        125000
`define MCR_MDC_KHZ         1670
// Half period of the management clock in pclk cycles, rounded down.
`define MCR_MDC_HALF        (`MCR_PCLK_KHZ / (2 * `MCR_MDC_KHZ))

// Half periods of the reference clock divider: divide by four or by two.
`define MCR_REF_HALF_MII    8'h02
`define MCR_REF_HALF_RMII   8'h01

// Reference input rising edges per half period of the 10 Mbps MII clock.
`define MCR_MII10_EDGES     3'h5

// Register byte offsets; the global ones sit inside 0F0h to 0FFh.
`define MCR_OFF_GL_CTRL1    12'h0F0
`define MCR_OFF_GL_ID       12'h0F4
`define MCR_OFF_GL_QPTR     12'h0F8
`define MCR_OFF_GL_CLKCFG   12'h0FC
`define MCR_OFF_SER_RST     12'h100
`define MCR_OFF_SER_TX      12'h104
`define MCR_OFF_SER_STAT    12'h108

// Field positions.
`define MCR_BIT_SW_RESET    0
`define MCR_BIT_REFCLK_OFF  1
`define MCR_BIT_DCE         0
`define MCR_BIT_SPEED100    1
`define MCR_BIT_RMII_PIN    2
`define MCR_BIT_TXCLK_PIN   3
`define MCR_BIT_RXCLK_PIN   4
`define MCR_BIT_SER_RST     0

// Identification values; arbitrary neutral values.
`define MCR_ID_LOW_DEF      8'h5A
`define MCR_ID_HIGH_DEF     8'hA5

`endif

/* File: common/mcr_pkg.sv */
/*
 * Types of the mapper clock and reset control block.
 * Assumes the constants header is compiled alongside.
 */
package mcr_pkg;

   // Clock configuration written by software.
   typedef struct packed {
      logic speed_100;
      logic dce_mode;
   } mcr_clk_cfg_t;

   // Drive of the two MII clock pins in DCE mode.
   typedef struct packed {
      logic clk;
      logic oe_n;
   } mcr_mii_drv_t;

   // Serial receive shifter state.
   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] cnt;
      logic [7:0] byte_q;
   } mcr_ser_rx_t;

   // Serial transmit shifter state.
   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] cnt;
      logic       data;
   } mcr_ser_tx_t;

endpackage

/* File: rtl/mcr_clkdiv.sv */
/*
 * Clock divider on pclk: the output toggles every half_count cycles.
 * Assumes hold comes from logic on pclk; hold parks the output low.
 */
`timescale 1ns/10ps
`default_nettype none

module mcr_clkdiv #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         hold,
   input  wire logic [W-1:0] half_count,
   output logic             clk_out
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         clk_reg;
   logic         clk_next;

   // Counts up to the half period; a shorter half period takes effect at once.
   always_comb begin
      cnt_next = cnt_reg + W'(1);
      clk_next = clk_reg;
      if (hold) begin
         cnt_next = '0;
         clk_next = 1'b0;
      end else if (cnt_reg >= half_count - W'(1)) begin
         cnt_next = '0;
         clk_next = ~clk_reg;
      end
   end

   // Registers the counter and the output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         clk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
      end
   end

   assign clk_out = clk_reg;

endmodule

`default_nettype wire

/* File: dv/mcr_phy_model.sv */
/*
 * Far-side model: PHY reference and MII clocks, serial line source.
 * Assumes the bench calls send_byte for each serial byte.
 */
`timescale 1ns/10ps
`default_nettype none

module mcr_phy_model (
   input  wire logic rmii,
   output logic      ref_clk,
   output logic      mii_clk,
   output logic      ser_clk,
   output logic      ser_data
);
   // Reference runs free at 25 MHz for MII or 50 MHz for RMII, its edges kept off pclk edges.
   initial begin
      ref_clk = 1'b0;
      #1;
      forever #((rmii === 1'b1) ? 10 : 20) ref_clk = ~ref_clk;
   end

   // In DTE the PHY supplies the MII clocks from its reference.
   assign mii_clk = ref_clk;

   // Serial clock idles low between frames; data shows the inverse of the last bit.
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b1;
   end

   // Sends one byte MSB first with a gap in mid-byte.
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         ser_data = b[i];
         #30 ser_clk = 1'b1;
         #61 ser_clk = 1'b0;
         #31;
         if (i == 4) #700;
      end
      ser_data = ~b[0];
   endtask
endmodule

`default_nettype wire

/* File: dv/test_mapper_clock_reset_control.sv */
/*
 * Self-checking bench of the mapper clock and reset control block.
 * Assumes the constants header and the PHY model are compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mcr_defines.svh"

module test_mapper_clock_reset_control;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        oe_n, sel_pin, ref_clk, mii_clk, tx_clk, tx_oe_n, sdram_clk, refclk, mdc;
   logic        ser_clk, ser_data, qpulse, ser_rst, ser_tx, rx_clk, rx_oe_n;
   int          fail_count, comparisons, qcount, p;

   // Clock of 8 ns.
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   mcr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_out_oe_n(oe_n), .reduced_mii_select_pin(sel_pin), .ref_clk_in(ref_clk),
      .mii_tx_clk_in(mii_clk), .mii_rx_clk_in(mii_clk), .mii_tx_clk_out(tx_clk),
      .mii_tx_clk_oe_n(tx_oe_n), .mii_rx_clk_out(rx_clk), .mii_rx_clk_oe_n(rx_oe_n), .sdram_clock_out(sdram_clk),
      .divided_ethernet_refclk_out(refclk), .mdc_out(mdc), .serial_tx_line_clock(ser_clk),
      .serial_rx_line_clock(ser_clk), .serial_rx_data(ser_data), .serial_tx_data(ser_tx),
      .queue_ptr_reset_pulse(qpulse), .serial_iface_in_reset(ser_rst));

   mcr_phy_model u_phy (.rmii(sel_pin), .ref_clk(ref_clk), .mii_clk(mii_clk), .ser_clk(ser_clk),
      .ser_data(ser_data));

   // Counts queue pointer pulses.
   always @(posedge pclk) if (qpulse === 1'b1) qcount++;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One APB transfer; returns one idle edge after the access edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return refclk;
         1: return mdc;
         3: return rx_clk;
         default: return tx_clk;
      endcase
   endfunction

   // Period in pclk cycles between two rising edges of a clock output.
   task automatic meas(input int s, output int per);
      int   n;
      logic prev;
      repeat (2) begin
         n = 0;
         do begin
            prev = pick(s);
            @(negedge pclk);
            n++;
         end while (!(prev === 1'b0 && pick(s) === 1'b1) && n < 300);
         if (n >= 300) begin
            fail_count++;
            final_report();
         end
      end
      per = n;
      @(posedge pclk);
   endtask

   task automatic t_reset();
      check("bus float", oe_n, 1);
      presetn <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      check("bus driven", oe_n, 0);
      @(posedge pclk);
      apb(0, `MCR_OFF_GL_ID, 0);
      check("id", rd, {16'h0000, `MCR_ID_HIGH_DEF, `MCR_ID_LOW_DEF});
      check("id err", err, 0);
      apb(0, 12'h0EC, 0);
      check("unmapped err", err, 1);
      apb(1, `MCR_OFF_SER_TX, 0);
   endtask

   task automatic t_clocks();
      meas(0, p);
      check("ref mii", 32'(p), 4);
      sel_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      meas(0, p);
      check("ref rmii", 32'(p), 2);
      sel_pin <= 1'b0;
      meas(1, p);
      check("mdc", 32'(p), 2 * `MCR_MDC_HALF);
      #1 check("sdram", sdram_clk, pclk);
      @(posedge pclk);
      apb(1, `MCR_OFF_GL_CTRL1, 2);
      p = 0;
      repeat (16) @(negedge pclk) p += refclk;
      check("ref off", 32'(p), 0);
      @(posedge pclk);
      apb(1, `MCR_OFF_GL_CTRL1, 0);
   endtask

   task automatic t_mii();
      apb(1, `MCR_OFF_GL_CLKCFG, 3);
      @(posedge pclk);
      check("dce oe", tx_oe_n, 0);
      check("dce rx oe", rx_oe_n, 0);
      meas(2, p);
      check("mii 100", 32'(p), 5);
      apb(1, `MCR_OFF_GL_CLKCFG, 1);
      meas(2, p);
      check("mii 10", 32'(p), 50);
      meas(3, p);
      check("mii rx 10", 32'(p), 50);
      sel_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      check("rmii oe", tx_oe_n, 1);
      sel_pin <= 1'b0;
      apb(1, `MCR_OFF_GL_CLKCFG, 0);
      repeat (4) @(posedge pclk);
      check("dte oe", tx_oe_n, 1);
      check("dte rx oe", rx_oe_n, 1);
   endtask

   task automatic t_swreset();
      apb(1, `MCR_OFF_GL_CLKCFG, 3);
      apb(1, `MCR_OFF_GL_CTRL1, 1);
      apb(0, `MCR_OFF_GL_CTRL1, 0);
      check("sw sticky", rd[0], 1);
      apb(0, `MCR_OFF_GL_CLKCFG, 0);
      check("cfg cleared", rd[1:0], 0);
      apb(1, `MCR_OFF_SER_RST, 1);
      check("ser held", ser_rst, 0);
      apb(1, `MCR_OFF_GL_CTRL1, 0);
      apb(1, `MCR_OFF_SER_RST, 1);
      check("ser set", ser_rst, 1);
      apb(1, `MCR_OFF_GL_CTRL1, 1);
      @(posedge pclk);
      check("ser cleared", ser_rst, 0);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `MCR_OFF_GL_CTRL1, 0);
      check("pin clears sw", rd[0], 0);
   endtask

   task automatic t_queue();
      qcount = 0;
      apb(1, `MCR_OFF_GL_QPTR, 0);
      apb(1, `MCR_OFF_GL_QPTR, 0);
      apb(1, `MCR_OFF_GL_CTRL1, 1);
      apb(1, `MCR_OFF_GL_QPTR, 0);
      apb(1, `MCR_OFF_GL_CTRL1, 0);
      check("qptr pulses", 32'(qcount), 2);
   endtask

   task automatic t_serial();
      apb(1, `MCR_OFF_SER_TX, 32'h0000_005A);
      u_phy.send_byte(8'hA5);
      repeat (8) @(posedge pclk);
      check("tx last bit", ser_tx, 0);
      apb(0, `MCR_OFF_SER_STAT, 0);
      check("rx byte", rd[7:0], 8'hA5);
      apb(1, `MCR_OFF_SER_RST, 1);
      apb(0, `MCR_OFF_SER_STAT, 0);
      check("rx reset", rd[7:0], 0);
      check("tx reset", ser_tx, 1);
      apb(1, `MCR_OFF_SER_RST, 0);
   endtask

   // Reset for 16 cycles, then the scenarios in turn.
   initial begin
      {presetn, psel, penable, pwrite, sel_pin} = 5'b0_0000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      {fail_count, comparisons, qcount} = {32'd0, 32'd0, 32'd0};
      repeat (16) @(posedge pclk);
      t_reset();
      t_clocks();
      t_mii();
      t_swreset();
      t_queue();
      t_serial();
      final_report();
   end
endmodule

`default_nettype wire
